// >>> logic/qbp_pkg.sv
// constants for the quasi-bidirectional port block
// Overview of operation
// R1: bit latch captures bus on write strobe
// R2: read-latch strobe returns latch contents
// R3: read-pin strobe returns sampled pin level
// R4: read-modify-write operands come from latches
// R5: reset sets every latch bit to one
// R6: input use needs a one in latch
// R7: every bit works independently as input/output
// R8: alternate output only while latch holds one
// R9: port three pin follows alternate output
// R10: port three pin level feeds alternate inputs
// R11: port three alternate function bit order
// R12: larger variant: port one counter two inputs
// R13: external access switches ports zero, two drivers
// R14: external access keeps two, writes ones zero
// R15: zero muxes address/data, two high address
// R16: no general I/O on bus ports
// R17: port zero pull-up only emitting bus ones
// R18: latch change reaches pin at S1P1 (the code passes it to the pin at P1 of every state)
// R19: strong pull-up two periods on rising latch
// R20: keeper holds high, released by external low
// R21: very weak pull-up whenever pull-down off
// R22: port two strong pull-up on address ones
// R23: four ports of eight independent bits
package qbp_pkg;
   localparam int PORT_COUNT = 4;
   localparam int PORT_WIDTH = 8;
   localparam logic [7:0] LATCH_RESET = 8'hff;
   localparam logic [7:0] BUS_FILL_ONES = 8'hff;
   // osc periods per state and states per machine cycle
   localparam int PHASES_PER_STATE = 2;
   localparam int STATES_PER_CYCLE = 6;
   localparam int STRONG_PULLUP_PERIODS = 2;
   // port three alternate bit positions
   localparam int ALT_SERIAL_IN = 0;
   localparam int ALT_SERIAL_OUT = 1;
   localparam int ALT_IRQ_ZERO = 2;
   localparam int ALT_IRQ_ONE = 3;
   localparam int ALT_COUNTER_ZERO = 4;
   localparam int ALT_COUNTER_ONE = 5;
   localparam int ALT_STORE_STROBE = 6;
   localparam int ALT_READ_STROBE = 7;
   // port one alternate bit positions on the larger variant
   localparam int ALT_COUNTER_TWO = 0;
   localparam int ALT_COUNTER_TWO_TRIGGER = 1;
   typedef enum logic [1:0] {QBP_PORT_ZERO, QBP_PORT_ONE, QBP_PORT_TWO, QBP_PORT_THREE} qbp_port_t;
endpackage

// >>> logic/qbp_pullup.sv
// pull-up control for one quasi-bidirectional bit
`timescale 1ns/100ps
`default_nettype none
module qbp_pullup (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic osc_tick,
   input wire logic s1_start,
   input wire logic drive_level,
   input wire logic hold_strong,
   input wire logic pin_in,
   output logic strong_pullup,
   output logic keeper_pullup,
   output logic very_weak_pullup
);
   logic prev_reg;
   logic prev_next;
   logic [1:0] strong_cnt_reg;
   logic [1:0] strong_cnt_next;
   logic keep_reg;
   logic keep_next;

   always_comb begin
      prev_next = prev_reg;
      strong_cnt_next = strong_cnt_reg;
      keep_next = keep_reg;
      if (s1_start) begin
         prev_next = drive_level;
         if (drive_level && !prev_reg) begin
            // the first period is covered directly at S1P1, the counter holds the rest
            strong_cnt_next = 2'(qbp_pkg::STRONG_PULLUP_PERIODS - 1); // [R19]
         end
      end else if (osc_tick && strong_cnt_reg != 2'h0) begin
         strong_cnt_next = strong_cnt_reg - 2'h1;
      end
      // a strong pulse wins over a low pin in the same clock; the low releases it afterwards
      if (!drive_level) begin
         keep_next = 1'b0;
      end else if (strong_pullup) begin
         keep_next = 1'b1; // [R20]
      end else if (!pin_in) begin
         keep_next = 1'b0; // [R20]
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_reg <= 1'b1;
         strong_cnt_reg <= 2'h0;
         keep_reg <= 1'b1;
      end else begin
         prev_reg <= prev_next;
         strong_cnt_reg <= strong_cnt_next;
         keep_reg <= keep_next;
      end
   end

   assign strong_pullup = drive_level &&
      (hold_strong || strong_cnt_reg != 2'h0 || (s1_start && !prev_reg)); // [R19] [R22]
   assign keeper_pullup = drive_level && (keep_reg || strong_pullup); // [R20]
   assign very_weak_pullup = drive_level; // [R21]
endmodule
`default_nettype wire

// >>> logic/qbp_port_logic.sv
// four ports with latches, read paths and drivers; ports one to three quasi-bidirectional, port zero open drain outside bus ones
`timescale 1ns/100ps
`default_nettype none
module qbp_port_logic #(
   parameter int WIDTH = qbp_pkg::PORT_WIDTH,
   parameter bit LARGE_VARIANT = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [1:0] port_sel,
   input wire logic [WIDTH-1:0] bus_wdata,
   input wire logic write_latch,
   input wire logic read_latch,
   input wire logic read_pin,
   output logic [WIDTH-1:0] bus_rdata,
   input wire logic ext_access,
   input wire logic addr_wide,
   input wire logic [WIDTH-1:0] addr_high,
   input wire logic [WIDTH-1:0] muxed_bus_out,
   input wire logic muxed_bus_drive,
   input wire logic [WIDTH-1:0] alt_out,
   output logic [WIDTH-1:0] port_three_alt_in,
   output logic counter_two_input,
   output logic counter_two_capture_trigger,
   output logic [WIDTH-1:0] muxed_bus_in,
   output logic serial_in,
   output logic external_irq_zero,
   output logic external_irq_one,
   output logic counter_zero_input,
   output logic counter_one_input,
   input wire logic [WIDTH-1:0] pin_zero_in,
   input wire logic [WIDTH-1:0] pin_one_in,
   input wire logic [WIDTH-1:0] pin_two_in,
   input wire logic [WIDTH-1:0] pin_three_in,
   output logic [WIDTH*4-1:0] pin_out,
   output logic [WIDTH*4-1:0] pin_oe,
   output logic [WIDTH*4-1:0] strong_pullup,
   output logic [WIDTH*4-1:0] keeper_pullup,
   output logic [WIDTH*4-1:0] very_weak_pullup,
   output logic machine_cycle_start
);
   typedef enum logic [0:0] {QBP_PHASE_ONE, QBP_PHASE_TWO} qbp_phase_t;
   localparam int STATE_BITS = 3;

   logic [WIDTH-1:0] latch_reg [4];
   logic [WIDTH-1:0] latch_next [4];
   logic [WIDTH-1:0] buf_reg [4];
   logic [WIDTH-1:0] buf_next [4];
   logic [WIDTH-1:0] buf_view [4];
   logic [WIDTH-1:0] rdata_reg;
   logic [WIDTH-1:0] rdata_next;
   logic [WIDTH-1:0] pins [4];
   logic [WIDTH-1:0] drive [4];
   logic [WIDTH-1:0] hold [4];
   qbp_phase_t phase_reg;
   qbp_phase_t phase_next;
   logic [STATE_BITS-1:0] state_reg;
   logic [STATE_BITS-1:0] state_next;
   logic s1_start;

   function automatic logic [WIDTH-1:0] sel_word(input logic [WIDTH-1:0] w [4],
                                                 input logic [1:0] s);
      sel_word = w[s];
   endfunction

   assign pins[0] = pin_zero_in;
   assign pins[1] = pin_one_in;
   assign pins[2] = pin_two_in;
   assign pins[3] = pin_three_in;

   // one state is two oscillator periods; each clock stands for one period
   always_comb begin
      phase_next = (phase_reg == QBP_PHASE_ONE) ? QBP_PHASE_TWO : QBP_PHASE_ONE;
      state_next = state_reg;
      if (phase_reg == QBP_PHASE_TWO) begin
         state_next = (state_reg == STATE_BITS'(qbp_pkg::STATES_PER_CYCLE - 1)) ?
                      '0 : state_reg + 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase_reg <= QBP_PHASE_ONE;
         state_reg <= '0;
      end else begin
         phase_reg <= phase_next;
         state_reg <= state_next;
      end
   end

   // pulse marks S1P1; buffers take new latch values at P1 of every state
   assign s1_start = (state_reg == '0) && (phase_reg == QBP_PHASE_ONE); // [R18]
   assign machine_cycle_start = s1_start;

   always_comb begin
      rdata_next = rdata_reg;
      for (int p = 0; p < qbp_pkg::PORT_COUNT; p++) begin
         latch_next[p] = latch_reg[p];
         buf_next[p] = buf_reg[p];
         if (phase_reg == QBP_PHASE_ONE) begin
            buf_next[p] = latch_reg[p]; // [R18]
         end
      end
      if (write_latch) begin
         latch_next[port_sel] = bus_wdata; // [R1] [R7]
      end
      // bus cycle wins over a software write to port zero
      if (ext_access) begin
         latch_next[0] = qbp_pkg::BUS_FILL_ONES; // [R14]
      end
      if (read_latch) begin
         rdata_next = sel_word(latch_reg, port_sel); // [R2] [R4]
      end else if (read_pin) begin
         rdata_next = sel_word(pins, port_sel); // [R3]
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int p = 0; p < qbp_pkg::PORT_COUNT; p++) begin
            latch_reg[p] <= qbp_pkg::LATCH_RESET; // [R5]
            buf_reg[p] <= qbp_pkg::LATCH_RESET;
         end
         rdata_reg <= '0;
      end else begin
         for (int p = 0; p < qbp_pkg::PORT_COUNT; p++) begin
            latch_reg[p] <= latch_next[p];
            buf_reg[p] <= buf_next[p];
         end
         rdata_reg <= rdata_next;
      end
   end

   assign bus_rdata = rdata_reg;

   // outside bus access a latch holding one turns the pull-down off (on port three only while alt_out is one), leaving the pin to outside drivers
   always_comb begin
      // phase one passes the latch through, phase two holds what phase one saw
      for (int p = 0; p < qbp_pkg::PORT_COUNT; p++) begin
         buf_view[p] = (phase_reg == QBP_PHASE_ONE) ? latch_reg[p] : buf_reg[p]; // [R18]
      end
      drive[1] = buf_view[1]; // [R6]
      drive[2] = (ext_access && addr_wide) ? addr_high : buf_view[2]; // [R13] [R15]
      drive[3] = buf_view[3] & alt_out; // [R8] [R9]
      drive[0] = ext_access ? (muxed_bus_drive ? muxed_bus_out : '1) : buf_view[0]; // [R13] [R15]
      hold[0] = '0;
      hold[1] = '0;
      hold[3] = '0;
      hold[2] = (ext_access && addr_wide) ? addr_high : '0; // [R22]
   end

   // pull-down active on zero bits of every port; port zero drives high only in bus ones
   always_comb begin
      for (int p = 0; p < qbp_pkg::PORT_COUNT; p++) begin
         pin_out[p*WIDTH +: WIDTH] = drive[p];
         pin_oe[p*WIDTH +: WIDTH] = ~drive[p];
      end
      if (ext_access && muxed_bus_drive) begin
         pin_oe[WIDTH-1:0] = '1; // [R17]
      end
   end

   genvar g;
   generate
      for (g = 0; g < WIDTH * qbp_pkg::PORT_COUNT; g++) begin : g_bit
         if (g < WIDTH) begin : g_open
            // port zero is open drain outside bus ones
            assign strong_pullup[g] = ext_access && muxed_bus_drive && drive[0][g]; // [R17]
            assign keeper_pullup[g] = 1'b0;
            assign very_weak_pullup[g] = 1'b0;
         end else begin : g_quasi
            qbp_pullup u_pullup (
               .ref_clk(ref_clk),
               .rst_n(rst_n),
               .osc_tick(1'b1),
               .s1_start(s1_start),
               .drive_level(drive[g / WIDTH][g % WIDTH]),
               .hold_strong(hold[g / WIDTH][g % WIDTH]),
               .pin_in(pins[g / WIDTH][g % WIDTH]),
               .strong_pullup(strong_pullup[g]),
               .keeper_pullup(keeper_pullup[g]),
               .very_weak_pullup(very_weak_pullup[g])
            ); // [R23]
         end
      end
   endgenerate

   assign port_three_alt_in = pin_three_in; // [R10]
   assign serial_in = pin_three_in[qbp_pkg::ALT_SERIAL_IN]; // [R11]
   assign external_irq_zero = pin_three_in[qbp_pkg::ALT_IRQ_ZERO]; // [R11]
   assign external_irq_one = pin_three_in[qbp_pkg::ALT_IRQ_ONE]; // [R11]
   assign counter_zero_input = pin_three_in[qbp_pkg::ALT_COUNTER_ZERO]; // [R11]
   assign counter_one_input = pin_three_in[qbp_pkg::ALT_COUNTER_ONE]; // [R11]
   assign muxed_bus_in = pin_zero_in;
   assign counter_two_input = LARGE_VARIANT ? pin_one_in[qbp_pkg::ALT_COUNTER_TWO] : 1'b0; // [R12]
   assign counter_two_capture_trigger =
      LARGE_VARIANT ? pin_one_in[qbp_pkg::ALT_COUNTER_TWO_TRIGGER] : 1'b0; // [R12]
endmodule
`default_nettype wire

// >>> verification/qbp_port_properties.sv
// concurrent checks on the port block pins
`timescale 1ns/100ps
`default_nettype none
module qbp_port_properties #(
   parameter int WIDTH = 8,
   parameter bit LARGE_VARIANT = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic ext_access,
   input wire logic muxed_bus_drive,
   input wire logic [WIDTH-1:0] muxed_bus_out,
   input wire logic [WIDTH-1:0] pin_zero_in,
   input wire logic [WIDTH-1:0] pin_one_in,
   input wire logic [WIDTH-1:0] pin_three_in,
   input wire logic [WIDTH-1:0] port_three_alt_in,
   input wire logic [WIDTH-1:0] muxed_bus_in,
   input wire logic serial_in,
   input wire logic counter_two_input,
   input wire logic counter_two_capture_trigger,
   input wire logic [WIDTH*4-1:0] pin_out,
   input wire logic [WIDTH*4-1:0] strong_pullup,
   input wire logic [WIDTH*4-1:0] keeper_pullup,
   input wire logic [WIDTH*4-1:0] very_weak_pullup,
   input wire logic machine_cycle_start
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_alt_in_follow:
      assert property (port_three_alt_in == pin_three_in) else $error("alt input stale");
   a_serial_in_bit:
      assert property (serial_in == pin_three_in[0]) else $error("serial input bit wrong");
   a_counter_two_pins:
      assert property ({counter_two_capture_trigger, counter_two_input} ==
         (LARGE_VARIANT ? pin_one_in[1:0] : 2'h0)) else $error("counter two pins wrong");
   a_bus_pass_in:
      assert property (muxed_bus_in == pin_zero_in) else $error("bus input wrong");
   // five clocks of stable bus drive first; port zero takes the bus value directly, not through the output buffer
   a_bus_drive_out:
      assert property ((ext_access && muxed_bus_drive && $stable(muxed_bus_out))[*5] |->
         pin_out[WIDTH-1:0] == muxed_bus_out) else $error("bus output not driven");
   a_cycle_period:
      assert property (machine_cycle_start |=> (!machine_cycle_start)[*8] ##4 machine_cycle_start)
         else $error("machine cycle length wrong");
   a_strong_two_clk:
      assert property ($rose(strong_pullup[WIDTH]) |=> strong_pullup[WIDTH] ##1
         !strong_pullup[WIDTH]) else $error("strong pull-up pulse length wrong");
   a_zero_no_keeper:
      assert property (keeper_pullup[WIDTH-1:0] == '0 && very_weak_pullup[WIDTH-1:0] == '0)
         else $error("port zero has a pull-up");
endmodule
bind qbp_port_logic qbp_port_properties #(.WIDTH(WIDTH), .LARGE_VARIANT(LARGE_VARIANT)) u_props (
   .ref_clk(ref_clk), .rst_n(rst_n), .ext_access(ext_access), .muxed_bus_drive(muxed_bus_drive),
   .muxed_bus_out(muxed_bus_out), .pin_zero_in(pin_zero_in), .pin_one_in(pin_one_in),
   .pin_three_in(pin_three_in), .port_three_alt_in(port_three_alt_in),
   .muxed_bus_in(muxed_bus_in), .serial_in(serial_in), .counter_two_input(counter_two_input),
   .counter_two_capture_trigger(counter_two_capture_trigger), .pin_out(pin_out),
   .strong_pullup(strong_pullup), .keeper_pullup(keeper_pullup),
   .very_weak_pullup(very_weak_pullup), .machine_cycle_start(machine_cycle_start));
`default_nettype wire

// >>> verification/qbp_pin_model.sv
// external circuitry on the package pins
`timescale 1ns/100ps
`default_nettype none
module qbp_pin_model (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [31:0] pin_out,
   input wire logic [31:0] pin_oe,
   input wire logic [31:0] pullup_any,
   input wire logic [31:0] ext_low,
   output logic [31:0] pin_level
);
   logic [31:0] last_reg;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         last_reg <= '0;
      end else begin
         last_reg <= pin_level;
      end
   end
   // a pulled-low line only wins while the pull-down is off; a bare line toggles, never holds
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ~ext_low & (pullup_any | ~last_reg));
endmodule
`default_nettype wire

// >>> verification/test_quasi_bidir_port_logic.sv
// self-checking bench for the port block
`timescale 1ns/100ps
`default_nettype none
module test_quasi_bidir_port_logic;
   logic ref_clk, rst_n, write_latch, read_latch, read_pin, ext_access, addr_wide, muxed_bus_drive;
   logic [1:0] port_sel;
   logic [3:0] taps;
   logic [7:0] bus_wdata, addr_high, muxed_bus_out, alt_out, bus_rdata, d;
   logic [31:0] pin_out, pin_oe, strong_pullup, keeper_pullup, very_weak_pullup, pin_level, ext_en;
   int mismatches, num_checks, n;
   qbp_port_logic dut (.ref_clk(ref_clk), .rst_n(rst_n), .port_sel(port_sel), .bus_wdata(bus_wdata),
      .write_latch(write_latch), .read_latch(read_latch), .read_pin(read_pin),
      .bus_rdata(bus_rdata), .ext_access(ext_access), .addr_wide(addr_wide), .addr_high(addr_high),
      .muxed_bus_out(muxed_bus_out), .muxed_bus_drive(muxed_bus_drive), .alt_out(alt_out),
      .port_three_alt_in(), .counter_two_input(), .counter_two_capture_trigger(), .muxed_bus_in(),
      .serial_in(), .external_irq_zero(taps[0]), .external_irq_one(taps[1]),
      .counter_zero_input(taps[2]), .counter_one_input(taps[3]),
      .pin_zero_in(pin_level[7:0]), .pin_one_in(pin_level[15:8]),
      .pin_two_in(pin_level[23:16]), .pin_three_in(pin_level[31:24]), .pin_out(pin_out),
      .pin_oe(pin_oe), .strong_pullup(strong_pullup), .keeper_pullup(keeper_pullup),
      .very_weak_pullup(very_weak_pullup), .machine_cycle_start());
   qbp_pin_model far (.ref_clk(ref_clk), .rst_n(rst_n), .pin_out(pin_out), .pin_oe(pin_oe),
      .pullup_any(strong_pullup | keeper_pullup | very_weak_pullup), .ext_low(ext_en),
      .pin_level(pin_level));
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one strobe cycle: write, latch read, or pin read when neither flag is set
   task automatic op(input logic w, input logic l, input logic [1:0] p, input logic [7:0] v);
      @(negedge ref_clk);
      port_sel = p;
      bus_wdata = v;
      write_latch = w;
      read_latch = l;
      read_pin = !(w || l);
      @(negedge ref_clk);
      {write_latch, read_latch, read_pin} = 3'h0;
      d = bus_rdata;
   endtask
   // long enough for the next machine cycle start plus the buffer copy
   task automatic wt;
      repeat (30) @(negedge ref_clk);
   endtask
   task automatic t_reset_values;
      for (int p = 0; p < 4; p++) begin
         op(1'h0, 1'h1, 2'(p), 8'h00);
         chk(d, 8'hff);
      end
   endtask
   task automatic t_latch_pin;
      op(1'h1, 1'h0, 2'h1, 8'h5a);
      op(1'h0, 1'h1, 2'h1, 8'h00);
      chk(d, 8'h5a);
      ext_en[9] = 1'h1;
      wt();
      chk(pin_oe[15:8], 8'ha5);
      op(1'h0, 1'h0, 2'h1, 8'h00);
      chk(d, 8'h58);
      op(1'h0, 1'h1, 2'h1, 8'h00);
      chk(d, 8'h5a);
      ext_en = '0;
   endtask
   task automatic t_strong_pulse;
      wt();
      op(1'h1, 1'h0, 2'h1, 8'h01);
      n = 0;
      repeat (30) begin
         @(negedge ref_clk);
         n += int'(strong_pullup[8] === 1'b1);
      end
      chk(n, 2);
      chk(keeper_pullup[8], 1'h1);
      ext_en[8] = 1'h1;
      wt();
      chk({keeper_pullup[8], very_weak_pullup[8]}, 2'h1);
      ext_en = '0;
   endtask
   task automatic t_ext_bus;
      op(1'h1, 1'h0, 2'h2, 8'h81);
      op(1'h1, 1'h0, 2'h0, 8'h12);
      wt();
      // software leaves both bus ports alone while the bus owns them
      {ext_access, addr_wide, muxed_bus_drive} = 3'h7;
      addr_high = 8'ha5;
      muxed_bus_out = 8'h3c;
      wt();
      chk(pin_out[7:0], 8'h3c);
      chk({strong_pullup[7:0], pin_oe[7:0]}, 16'h3cff);
      chk(pin_out[23:16], 8'ha5);
      chk(strong_pullup[23:16], 8'ha5);
      addr_wide = 1'h0;
      wt();
      chk(pin_out[23:16], 8'h81);
      {ext_access, muxed_bus_drive} = 2'h0;
      op(1'h0, 1'h1, 2'h0, 8'h00);
      chk(d, 8'hff);
      op(1'h0, 1'h1, 2'h2, 8'h00);
      chk(d, 8'h81);
   endtask
   task automatic t_alt_out;
      alt_out = 8'h55;
      wt();
      chk(pin_out[31:24], 8'h55);
      chk(taps, 4'h5);
      op(1'h1, 1'h0, 2'h3, 8'hf0);
      wt();
      chk(pin_out[31:24], 8'h50);
      chk(taps, 4'h4);
      chk({strong_pullup[7:0], pin_oe[7:0]}, 16'h0000);
   endtask
   task automatic tally_and_finish;
      if (mismatches == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      {rst_n, write_latch, read_latch, read_pin, ext_access, addr_wide, muxed_bus_drive} = '0;
      {port_sel, bus_wdata, addr_high, muxed_bus_out, ext_en} = '0;
      alt_out = 8'hff;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      rst_n = 1'b1;
      t_reset_values();
      t_latch_pin();
      t_strong_pulse();
      t_ext_bus();
      t_alt_out();
      tally_and_finish();
   end
   initial begin
      #40000;
      mismatches++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
